// ---- rtl/css_defs.vh ----
`ifndef CSS_DEFS_VH
`define CSS_DEFS_VH

// Command codes of the settings port
`define CSS_CMD_OPERATING_STATE 8'h01
`define CSS_CMD_ON_OFF_CONFIGURATION 8'h02
`define CSS_CMD_OUTPUT_FORMAT_MODE 8'h20
`define CSS_CMD_OUTPUT_TARGET 8'h21
`define CSS_CMD_OUTPUT_TRIM 8'h22
`define CSS_CMD_OUTPUT_CEILING 8'h24
`define CSS_CMD_UPPER_MARGIN_LEVEL 8'h25
`define CSS_CMD_LOWER_MARGIN_LEVEL 8'h26
`define CSS_CMD_FEEDBACK_DIVIDER_SCALE 8'h29
`define CSS_CMD_OUTPUT_FLOOR 8'h2b
`define CSS_CMD_OV_FAULT_THRESHOLD 8'h40
`define CSS_CMD_OV_WARNING_THRESHOLD 8'h42
`define CSS_CMD_UV_WARNING_THRESHOLD 8'h43
`define CSS_CMD_UV_FAULT_THRESHOLD 8'h44
`define CSS_CMD_TURN_ON_DELAY_TIME 8'h60
`define CSS_CMD_SOFT_START_DURATION 8'h61
`define CSS_CMD_TURN_OFF_DELAY_TIME 8'h64
`define CSS_CMD_SOFT_STOP_DURATION 8'h65
`define CSS_CMD_MISCELLANEOUS_OPTIONS 8'hed
`define CSS_CMD_STRAP_SOURCE_OVERRIDE 8'hee

// Storage indices
`define CSS_REG_COUNT 20
`define CSS_IDX_OP 5'h00
`define CSS_IDX_ONOFF 5'h01
`define CSS_IDX_MODE 5'h02
`define CSS_IDX_TARGET 5'h03
`define CSS_IDX_TRIM 5'h04
`define CSS_IDX_CEIL 5'h05
`define CSS_IDX_MHI 5'h06
`define CSS_IDX_MLO 5'h07
`define CSS_IDX_SCALE 5'h08
`define CSS_IDX_FLOOR 5'h09
`define CSS_IDX_OVF 5'h0a
`define CSS_IDX_OVW 5'h0b
`define CSS_IDX_UVW 5'h0c
`define CSS_IDX_UVF 5'h0d
`define CSS_IDX_TON 5'h0e
`define CSS_IDX_RISE 5'h0f
`define CSS_IDX_TOFF 5'h10
`define CSS_IDX_FALL 5'h11
`define CSS_IDX_MISC 5'h12
`define CSS_IDX_OVR 5'h13

// Reset values
`define CSS_RST_OP 16'h0080
`define CSS_RST_ONOFF 16'h0017
`define CSS_RST_MODE 16'h0000
`define CSS_RST_TRIM 16'h0000
`define CSS_RST_MARGIN 16'h0033
`define CSS_RST_OVF 16'h0066
`define CSS_RST_OVW 16'h0033
`define CSS_RST_UVW 16'h0033
`define CSS_RST_UVF 16'h0066
`define CSS_RST_TON 16'h0000
`define CSS_RST_TOFF 16'h0000
`define CSS_RST_FALL 16'h0000
`define CSS_RST_MISC 16'h0002
`define CSS_RST_OVR 16'h0000
`define CSS_RST_ZERO 16'h0000

// Field positions
`define CSS_OP_ON_BIT 7
`define CSS_OP_SOFTSTOP_BIT 6
`define CSS_OP_MARGIN_HI_BIT 5
`define CSS_OP_MARGIN_LO_BIT 4
`define CSS_ONOFF_USE_OP_BIT 3
`define CSS_ONOFF_USE_PIN_BIT 2
`define CSS_ONOFF_PIN_POL_BIT 1
`define CSS_ONOFF_PIN_CUT_BIT 0
`define CSS_MODE_ABS_BIT 7
`define CSS_MISC_RESET_ROLE_BIT 0
`define CSS_MISC_PULLUP_N_BIT 1
`define CSS_OVR_TARGET_NVM_BIT 0
`define CSS_SCALE_LSB 0
`define CSS_SCALE_MSB 1
`define CSS_RISE_MSB 6
`define CSS_REL_SHIFT 10

// Timing, in their own units
`define CSS_CLK_NS 40
`define CSS_TICK_NS 250000
`define CSS_TICK_US 250
`define CSS_POR_US 6000
`define CSS_FALL_MIN_US 500
`define CSS_LS_PERIODS 128
`define CSS_FRAC_FULL 8'hff

// Soft start choices of the multi-select strap, in 250 us steps
`define CSS_RISE_OPT0 7'h00
`define CSS_RISE_OPT1 7'h02
`define CSS_RISE_OPT2 7'h04
`define CSS_RISE_OPT3 7'h08
`define CSS_RISE_OPT4 7'h0c
`define CSS_RISE_OPT5 7'h14
`define CSS_RISE_OPT6 7'h28
`define CSS_RISE_OPT7 7'h7f

`endif

// ---- rtl/css_ramp.v ----
`timescale 1ns/1ps
`default_nettype none
`include "css_defs.vh"

module css_ramp #(
    parameter TICK_CYC = `CSS_TICK_NS / `CSS_CLK_NS
) (
    input wire clk,
    input wire sys_rst,
    input wire start,
    input wire down,
    input wire [6:0] len_ticks,
    output reg [7:0] frac_ff,
    output wire done
);
    reg run_ff;
    reg dir_ff;
    reg [31:0] err_ff;
    reg [31:0] den_ff;
    wire [31:0] nxt_err = err_ff + {24'h000000, `CSS_FRAC_FULL};

    ////////////////////////////////////////////////////////////////////////////
    // Spread the 0..full sweep evenly over len_ticks ticks
    always @(posedge clk) begin
        if (sys_rst) begin
            run_ff <= 1'b0;
            dir_ff <= 1'b0;
            err_ff <= 32'h00000000;
            den_ff <= 32'h00000000;
            frac_ff <= 8'h00;
        end else if (start) begin
            dir_ff <= down;
            err_ff <= 32'h00000000;
            den_ff <= {25'h0000000, len_ticks} * TICK_CYC;
            run_ff <= (len_ticks != 7'h00);
            if (len_ticks == 7'h00)
                frac_ff <= down ? 8'h00 : `CSS_FRAC_FULL;
            else
                frac_ff <= down ? `CSS_FRAC_FULL : 8'h00;
        end else if (run_ff) begin
            if (nxt_err >= den_ff) begin
                err_ff <= nxt_err - den_ff;
                frac_ff <= dir_ff ? frac_ff - 8'h01 : frac_ff + 8'h01;
                if ((dir_ff && frac_ff == 8'h01) || (!dir_ff && frac_ff == 8'hfe))
                    run_ff <= 1'b0;
            end else begin
                err_ff <= nxt_err;
            end
        end
    end

    assign done = !run_ff && !start;
endmodule // css_ramp

`default_nettype wire

// ---- rtl/css_sequencer.v ----
`timescale 1ns/1ps
`default_nettype none
`include "css_defs.vh"

// Function
// - Sense enable only after 6 ms reset
// - All good early: delay starts at reset end
// - Otherwise delay starts when all good
// - Divider ratio 1:1,1:2,1:4,1:8 selectable
// - Strap loads scale, target, floor, ceiling
// - Margins, limits relative unless absolute mode
// - Reset pin low restores power-on target
// - Target writes acked but dropped during reset
// - Pull-up bit clear enables internal reset pull-up
// - Reference ramps from zero to final level
// - Rise code 7 bits, 250 us steps
// - Rise from strap, bus, or both
// - Low side off until first high pulse
// - Low-side on-time grows over 128 periods
// - Overvoltage fault acts even when disabled
// - Soft stop ramps output down to zero
// - Fall code zero gives 0.5 ms fall
// - Without soft stop, cut both drivers
// - Pin turn-off defaults to no soft stop
// - Power good released only in regulation window
// - Shutdown fault pulls power good low
// - Enable pin may be ignored or inverted
module css_sequencer #(
    parameter TICK_CYC = `CSS_TICK_NS / `CSS_CLK_NS,
    parameter POR_TICKS = (`CSS_POR_US + `CSS_TICK_US - 1) / `CSS_TICK_US,
    parameter FALL_MIN_TICKS = (`CSS_FALL_MIN_US + `CSS_TICK_US - 1) / `CSS_TICK_US,
    parameter LS_PERIODS = `CSS_LS_PERIODS
) (
    input wire clk,
    input wire sys_rst,
    input wire analog_supply_ok,
    input wire driver_supply_ok,
    input wire input_supply_good,
    input wire enable_pin,
    input wire [15:0] strap_target,
    input wire [1:0] strap_scale,
    input wire [15:0] strap_floor,
    input wire [15:0] strap_ceiling,
    input wire [15:0] nvm_target,
    input wire [2:0] second_multiselect_code,
    input wire [15:0] sensed_output,
    input wire hs_pulse,
    input wire sw_period,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire cmd_wr,
    input wire cmd_rd,
    output wire cmd_ack,
    output reg [15:0] cmd_rdata_ff,
    output reg [15:0] ref_level_ff,
    output wire [1:0] divider_ratio,
    output wire hs_drv_en,
    output wire ls_drv_en,
    output reg [7:0] ls_limit_ff,
    output wire ls_full,
    output wire power_good_output,
    output wire ov_fault,
    output wire por_busy,
    input wire pgr_in,
    output wire pgr_out,
    output wire pgr_oe_n,
    output wire pgr_pullup_en
);
    localparam [6:0] S_POR = 7'b0000001;
    localparam [6:0] S_IDLE = 7'b0000010;
    localparam [6:0] S_TON = 7'b0000100;
    localparam [6:0] S_RISE = 7'b0001000;
    localparam [6:0] S_REG = 7'b0010000;
    localparam [6:0] S_TOFF = 7'b0100000;
    localparam [6:0] S_FALL = 7'b1000000;

    reg [15:0] regs_ff [0:`CSS_REG_COUNT-1];
    reg [6:0] state_ff;
    reg [6:0] nxt_state;
    reg [31:0] tick_div_ff;
    reg [15:0] tmr_ff;
    reg [15:0] por_target_ff;
    reg ramp_start_ff;
    reg ramp_down_ff;
    reg soft_stop_ff;
    reg hs_seen_ff;
    reg ov_fault_ff;
    reg uv_fault_ff;
    reg [4:0] idx;
    reg hit;
    integer i;

    wire tick = (tick_div_ff == TICK_CYC - 1);
    wire [7:0] ramp_frac;
    wire ramp_done;

    ////////////////////////////////////////////////////////////////////////////
    // Command decode
    always @* begin
        hit = 1'b1;
        case (cmd_code)
            `CSS_CMD_OPERATING_STATE: idx = `CSS_IDX_OP;
            `CSS_CMD_ON_OFF_CONFIGURATION: idx = `CSS_IDX_ONOFF;
            `CSS_CMD_OUTPUT_FORMAT_MODE: idx = `CSS_IDX_MODE;
            `CSS_CMD_OUTPUT_TARGET: idx = `CSS_IDX_TARGET;
            `CSS_CMD_OUTPUT_TRIM: idx = `CSS_IDX_TRIM;
            `CSS_CMD_OUTPUT_CEILING: idx = `CSS_IDX_CEIL;
            `CSS_CMD_UPPER_MARGIN_LEVEL: idx = `CSS_IDX_MHI;
            `CSS_CMD_LOWER_MARGIN_LEVEL: idx = `CSS_IDX_MLO;
            `CSS_CMD_FEEDBACK_DIVIDER_SCALE: idx = `CSS_IDX_SCALE;
            `CSS_CMD_OUTPUT_FLOOR: idx = `CSS_IDX_FLOOR;
            `CSS_CMD_OV_FAULT_THRESHOLD: idx = `CSS_IDX_OVF;
            `CSS_CMD_OV_WARNING_THRESHOLD: idx = `CSS_IDX_OVW;
            `CSS_CMD_UV_WARNING_THRESHOLD: idx = `CSS_IDX_UVW;
            `CSS_CMD_UV_FAULT_THRESHOLD: idx = `CSS_IDX_UVF;
            `CSS_CMD_TURN_ON_DELAY_TIME: idx = `CSS_IDX_TON;
            `CSS_CMD_SOFT_START_DURATION: idx = `CSS_IDX_RISE;
            `CSS_CMD_TURN_OFF_DELAY_TIME: idx = `CSS_IDX_TOFF;
            `CSS_CMD_SOFT_STOP_DURATION: idx = `CSS_IDX_FALL;
            `CSS_CMD_MISCELLANEOUS_OPTIONS: idx = `CSS_IDX_MISC;
            `CSS_CMD_STRAP_SOURCE_OVERRIDE: idx = `CSS_IDX_OVR;
            default: begin
                idx = 5'h00;
                hit = 1'b0;
            end
        endcase
    end

    // Settings are only answered once reset detection has finished
    assign por_busy = state_ff[0];
    assign cmd_ack = (cmd_wr || cmd_rd) && hit && !por_busy;

    ////////////////////////////////////////////////////////////////////////////
    // Decoded settings
    wire [15:0] op = regs_ff[`CSS_IDX_OP];
    wire [15:0] onoff = regs_ff[`CSS_IDX_ONOFF];
    wire [15:0] misc = regs_ff[`CSS_IDX_MISC];
    wire [15:0] target = regs_ff[`CSS_IDX_TARGET];
    wire absolute = regs_ff[`CSS_IDX_MODE][`CSS_MODE_ABS_BIT];
    wire reset_role = misc[`CSS_MISC_RESET_ROLE_BIT];
    wire reset_held = reset_role && !pgr_in;
    assign divider_ratio = regs_ff[`CSS_IDX_SCALE][`CSS_SCALE_MSB:`CSS_SCALE_LSB];
    assign pgr_pullup_en = reset_role && !misc[`CSS_MISC_PULLUP_N_BIT];

    // Relative limit: target plus or minus target*value/1024
    function [15:0] lim;
        input abs_fmt;
        input up;
        input [15:0] tgt;
        input [15:0] val;
        reg [31:0] delta;
        begin
            delta = ({16'h0000, tgt} * {16'h0000, val}) >> `CSS_REL_SHIFT;
            if (abs_fmt)
                lim = val;
            else if (up)
                lim = tgt + delta[15:0];
            else
                lim = (delta[15:0] > tgt) ? 16'h0000 : tgt - delta[15:0];
        end
    endfunction

    function [6:0] rise_opt;
        input [2:0] sel;
        begin
            case (sel)
                3'h0: rise_opt = `CSS_RISE_OPT0;
                3'h1: rise_opt = `CSS_RISE_OPT1;
                3'h2: rise_opt = `CSS_RISE_OPT2;
                3'h3: rise_opt = `CSS_RISE_OPT3;
                3'h4: rise_opt = `CSS_RISE_OPT4;
                3'h5: rise_opt = `CSS_RISE_OPT5;
                3'h6: rise_opt = `CSS_RISE_OPT6;
                default: rise_opt = `CSS_RISE_OPT7;
            endcase
        end
    endfunction

    // Limits in absolute codes
    wire [15:0] ovf_lvl = lim(absolute, 1'b1, target, regs_ff[`CSS_IDX_OVF]);
    wire [15:0] ovw_lvl = lim(absolute, 1'b1, target, regs_ff[`CSS_IDX_OVW]);
    wire [15:0] uvw_lvl = lim(absolute, 1'b0, target, regs_ff[`CSS_IDX_UVW]);
    wire [15:0] uvf_lvl = lim(absolute, 1'b0, target, regs_ff[`CSS_IDX_UVF]);
    wire [15:0] mhi_lvl = lim(absolute, 1'b1, target, regs_ff[`CSS_IDX_MHI]);
    wire [15:0] mlo_lvl = lim(absolute, 1'b0, target, regs_ff[`CSS_IDX_MLO]);

    // Final level: margin or target, plus trim, clamped to floor and ceiling
    wire [15:0] base_lvl = op[`CSS_OP_MARGIN_HI_BIT] ? mhi_lvl :
                           op[`CSS_OP_MARGIN_LO_BIT] ? mlo_lvl : target;
    wire [15:0] trim_lvl = base_lvl + regs_ff[`CSS_IDX_TRIM];
    wire [15:0] final_lvl = (trim_lvl > regs_ff[`CSS_IDX_CEIL]) ? regs_ff[`CSS_IDX_CEIL] :
                            (trim_lvl < regs_ff[`CSS_IDX_FLOOR]) ? regs_ff[`CSS_IDX_FLOOR] :
                            trim_lvl;
    wire [23:0] ramp_lvl = final_lvl * ramp_frac;

    ////////////////////////////////////////////////////////////////////////////
    // Turn-on conditions
    wire pin_on = !onoff[`CSS_ONOFF_USE_PIN_BIT] ||
                  (enable_pin == onoff[`CSS_ONOFF_PIN_POL_BIT]);
    wire op_on = !onoff[`CSS_ONOFF_USE_OP_BIT] || op[`CSS_OP_ON_BIT];
    wire supplies_ok = driver_supply_ok && input_supply_good;
    wire run_req = pin_on && op_on && supplies_ok && !ov_fault_ff && !uv_fault_ff;
    wire fault_cut = ov_fault_ff || uv_fault_ff || !supplies_ok;
    // Soft stop per turn-off source: pin source uses its own bit
    wire want_soft = pin_on ? op[`CSS_OP_SOFTSTOP_BIT]
                            : !onoff[`CSS_ONOFF_PIN_CUT_BIT];
    wire [6:0] fall_code = regs_ff[`CSS_IDX_FALL][`CSS_RISE_MSB:0];
    wire [6:0] fall_len = (fall_code == 7'h00) ? FALL_MIN_TICKS[6:0] : fall_code;

    ////////////////////////////////////////////////////////////////////////////
    // Tick divider and state timer
    always @(posedge clk) begin
        if (sys_rst || tick)
            tick_div_ff <= 32'h00000000;
        else
            tick_div_ff <= tick_div_ff + 32'h00000001;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequence state machine
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_POR: begin
                if (tick && tmr_ff == POR_TICKS[15:0] - 16'h0001)
                    nxt_state = S_IDLE;
            end
            S_IDLE: begin
                if (run_req)
                    nxt_state = S_TON;
            end
            S_TON: begin
                if (fault_cut || !run_req)
                    nxt_state = S_IDLE;
                else if (tmr_ff >= regs_ff[`CSS_IDX_TON])
                    nxt_state = S_RISE;
            end
            S_RISE, S_REG: begin
                if (fault_cut)
                    nxt_state = S_IDLE;
                else if (!run_req)
                    nxt_state = S_TOFF;
                else if (state_ff == S_RISE && ramp_done && !ramp_start_ff)
                    nxt_state = S_REG;
            end
            S_TOFF: begin
                if (fault_cut)
                    nxt_state = S_IDLE;
                else if (tmr_ff >= regs_ff[`CSS_IDX_TOFF])
                    nxt_state = soft_stop_ff ? S_FALL : S_IDLE;
            end
            S_FALL: begin
                if (fault_cut || (ramp_done && !ramp_start_ff))
                    nxt_state = S_IDLE;
            end
            default: nxt_state = S_POR;
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= S_POR;
            tmr_ff <= 16'h0000;
            ramp_start_ff <= 1'b0;
            ramp_down_ff <= 1'b0;
            soft_stop_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            ramp_start_ff <= (nxt_state == S_RISE && state_ff != S_RISE) ||
                             (nxt_state == S_FALL && state_ff != S_FALL);
            if (nxt_state == S_FALL)
                ramp_down_ff <= 1'b1;
            else if (nxt_state == S_RISE)
                ramp_down_ff <= 1'b0;
            if (state_ff != S_TOFF && nxt_state == S_TOFF)
                soft_stop_ff <= want_soft;
            // POR timer counts only with the analog supply up
            if (nxt_state != state_ff || (state_ff == S_POR && !analog_supply_ok))
                tmr_ff <= 16'h0000;
            else if (tick && tmr_ff != 16'hffff)
                tmr_ff <= tmr_ff + 16'h0001;
        end
    end

    css_ramp #(
        .TICK_CYC(TICK_CYC)
    ) u_ramp (
        .clk(clk),
        .sys_rst(sys_rst),
        .start(ramp_start_ff),
        .down(ramp_down_ff),
        .len_ticks(ramp_down_ff ? fall_len : regs_ff[`CSS_IDX_RISE][`CSS_RISE_MSB:0]),
        .frac_ff(ramp_frac),
        .done(ramp_done)
    );

    // Reference follows the ramp, full level in regulation and turn-off delay, zero otherwise
    always @(posedge clk) begin
        if (sys_rst)
            ref_level_ff <= 16'h0000;
        else if (state_ff == S_RISE || state_ff == S_FALL)
            ref_level_ff <= ramp_lvl[23:8];
        else if (state_ff == S_REG || state_ff == S_TOFF)
            ref_level_ff <= final_lvl;
        else
            ref_level_ff <= 16'h0000;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Faults: overvoltage watched whenever reset is done and drivers are up
    always @(posedge clk) begin
        if (sys_rst) begin
            ov_fault_ff <= 1'b0;
            uv_fault_ff <= 1'b0;
        end else begin
            if (!por_busy && driver_supply_ok && sensed_output > ovf_lvl)
                ov_fault_ff <= 1'b1;
            else if (!(pin_on && op_on))
                ov_fault_ff <= 1'b0;
            if (state_ff == S_REG && sensed_output < uvf_lvl)
                uv_fault_ff <= 1'b1;
            else if (!(pin_on && op_on))
                uv_fault_ff <= 1'b0;
        end
    end
    assign ov_fault = ov_fault_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Prebias rectifier control
    wire converting = state_ff[3] || state_ff[4] || state_ff[5] || state_ff[6];
    always @(posedge clk) begin
        if (sys_rst || !converting) begin
            hs_seen_ff <= 1'b0;
            ls_limit_ff <= 8'h00;
        end else begin
            if (hs_pulse)
                hs_seen_ff <= 1'b1;
            if (hs_seen_ff && (ls_limit_ff != 8'h00 || sensed_output > ref_level_ff) &&
                    sw_period && ls_limit_ff != LS_PERIODS[7:0])
                ls_limit_ff <= ls_limit_ff + 8'h01;
        end
    end
    assign hs_drv_en = converting;
    assign ls_drv_en = converting && hs_seen_ff;
    assign ls_full = (ls_limit_ff == LS_PERIODS[7:0]) || state_ff == S_FALL;

    ////////////////////////////////////////////////////////////////////////////
    // Power good and open-drain pin
    assign power_good_output = state_ff == S_REG && !fault_cut && run_req &&
                               sensed_output > uvw_lvl && sensed_output < ovw_lvl;
    assign pgr_out = 1'b0;
    assign pgr_oe_n = reset_role || power_good_output;

    ////////////////////////////////////////////////////////////////////////////
    // Setting storage, strap load and command writes
    always @(posedge clk) begin
        if (sys_rst) begin
            for (i = 0; i < `CSS_REG_COUNT; i = i + 1)
                regs_ff[i] <= `CSS_RST_ZERO;
            regs_ff[`CSS_IDX_OP] <= `CSS_RST_OP;
            regs_ff[`CSS_IDX_ONOFF] <= `CSS_RST_ONOFF;
            regs_ff[`CSS_IDX_MODE] <= `CSS_RST_MODE;
            regs_ff[`CSS_IDX_MHI] <= `CSS_RST_MARGIN;
            regs_ff[`CSS_IDX_MLO] <= `CSS_RST_MARGIN;
            regs_ff[`CSS_IDX_OVF] <= `CSS_RST_OVF;
            regs_ff[`CSS_IDX_OVW] <= `CSS_RST_OVW;
            regs_ff[`CSS_IDX_UVW] <= `CSS_RST_UVW;
            regs_ff[`CSS_IDX_UVF] <= `CSS_RST_UVF;
            regs_ff[`CSS_IDX_MISC] <= `CSS_RST_MISC;
            por_target_ff <= `CSS_RST_ZERO;
        end else if (por_busy) begin
            // Straps are sampled throughout detection; last value stays
            regs_ff[`CSS_IDX_SCALE] <= {14'h0000, strap_scale};
            regs_ff[`CSS_IDX_FLOOR] <= strap_floor;
            regs_ff[`CSS_IDX_CEIL] <= strap_ceiling;
            regs_ff[`CSS_IDX_RISE] <= {9'h000, rise_opt(second_multiselect_code)};
            regs_ff[`CSS_IDX_TARGET] <= regs_ff[`CSS_IDX_OVR][`CSS_OVR_TARGET_NVM_BIT] ?
                                        nvm_target : strap_target;
            por_target_ff <= regs_ff[`CSS_IDX_OVR][`CSS_OVR_TARGET_NVM_BIT] ?
                             nvm_target : strap_target;
        end else begin
            if (cmd_wr && hit && !(idx == `CSS_IDX_TARGET && reset_held))
                regs_ff[idx] <= cmd_wdata;
            if (reset_held)
                regs_ff[`CSS_IDX_TARGET] <= por_target_ff;
        end
    end

    // Read data registered one cycle after the request
    always @(posedge clk) begin
        if (sys_rst)
            cmd_rdata_ff <= 16'h0000;
        else if (cmd_rd && hit && !por_busy)
            cmd_rdata_ff <= regs_ff[idx];
    end
endmodule // css_sequencer

`default_nettype wire

// ---- test/css_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module css_monitor (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] cmd_code,
    input wire logic cmd_wr,
    input wire logic cmd_ack,
    input wire logic por_busy,
    input wire logic hs_drv_en,
    input wire logic ls_drv_en,
    input wire logic [7:0] ls_limit_ff,
    input wire logic ls_full,
    input wire logic [15:0] ref_level_ff,
    input wire logic power_good_output,
    input wire logic ov_fault,
    input wire logic pgr_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Drivers just switched on
    sequence s_on;
        $rose(hs_drv_en);
    endsequence
    ////////////////////////////////////////
    a_ack_por: assert property (por_busy |-> !cmd_ack) else $error("ack in por");
    a_tgt_ack: assert property (cmd_wr && cmd_code == 8'h21 && !por_busy |-> cmd_ack)
        else $error("target write not acked");
    a_ls_start: assert property (s_on |-> !ls_drv_en) else $error("low side early");
    a_ref_zero: assert property (s_on |-> $past(ref_level_ff) == 16'h0000)
        else $error("ramp not from zero");
    a_ls_full: assert property (ls_full && power_good_output |-> ls_limit_ff == 8'h80)
        else $error("full early");
    a_ov_cut: assert property (ov_fault |=> !hs_drv_en && !ls_drv_en)
        else $error("drivers on in fault");
    a_pg_conv: assert property (power_good_output |-> hs_drv_en) else $error("pg while off");
    a_pg_por: assert property (por_busy |-> !power_good_output && !pgr_oe_n)
        else $error("pg in por");
    a_ov_pg: assert property (ov_fault |-> !power_good_output) else $error("pg in fault");
    a_pg_late: assert property (s_on |-> !power_good_output [*3]) else $error("pg in ramp");
endmodule // css_monitor
`default_nettype wire

// ---- test/css_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module css_host (
    input wire logic clk,
    input wire logic cmd_ack,
    input wire logic [15:0] cmd_rdata_ff,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    output logic cmd_wr,
    output logic cmd_rd
);
    initial {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = 26'h0;
    // One access, held across the taking edge
    task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic a, output logic [15:0] q);
        @(posedge clk);
        #1;
        {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = {w, !w, c, d};
        @(posedge clk);
        a = cmd_ack;
        #1;
        {cmd_wr, cmd_rd} = 2'b00;
        q = cmd_rdata_ff;
    endtask
endmodule // css_host
`default_nettype wire

// ---- test/tb_css_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_css_sequencer;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic pv = 1'b1;
    logic en = 1'b1;
    logic ext_low = 1'b0;
    logic [15:0] sense = 16'h0200;
    logic [15:0] st = 16'h0200;
    logic [1:0] sw_cnt = 2'h0;
    logic [2:0] msel = 3'h1;
    logic [15:0] q;
    logic a;
    int num_errors = 0;
    int checked = 0;
    int cyc = 0;
    wire logic [7:0] cmd_code;
    wire logic [15:0] cmd_wdata, cmd_rdata_ff;
    wire logic [1:0] divider_ratio;
    wire logic cmd_wr, cmd_rd, cmd_ack, hs_drv_en, ls_drv_en, ls_full, power_good_output;
    wire logic ov_fault, por_busy, pgr_oe_n, pgr_pullup_en, sw_period, hs_pulse, pgr_in;
    // Pin pulled up outside, pulled low by either party
    assign pgr_in = pgr_oe_n && !ext_low;
    // Power stage stand-in: a period every four clocks
    assign sw_period = sw_cnt == 2'h3;
    assign hs_pulse = sw_period && hs_drv_en;
    always @(posedge clk) sw_cnt <= sw_cnt + 2'h1;
    initial forever #20 clk = ~clk;
    css_host host (.clk(clk), .cmd_ack(cmd_ack), .cmd_rdata_ff(cmd_rdata_ff),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd));
    css_sequencer #(.TICK_CYC(4), .POR_TICKS(2)) dut (.clk(clk), .sys_rst(sys_rst),
        .analog_supply_ok(pv), .driver_supply_ok(pv), .input_supply_good(pv),
        .enable_pin(en), .strap_target(st), .strap_scale(2'h1), .strap_floor(16'h0100),
        .strap_ceiling(16'h0400), .nvm_target(~st), .second_multiselect_code(msel),
        .sensed_output(sense), .hs_pulse(hs_pulse), .sw_period(sw_period),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
        .cmd_ack(cmd_ack), .cmd_rdata_ff(cmd_rdata_ff), .ref_level_ff(),
        .divider_ratio(divider_ratio), .hs_drv_en(hs_drv_en), .ls_drv_en(ls_drv_en),
        .ls_limit_ff(), .ls_full(ls_full), .power_good_output(power_good_output),
        .ov_fault(ov_fault), .por_busy(por_busy), .pgr_in(pgr_in), .pgr_out(),
        .pgr_oe_n(pgr_oe_n), .pgr_pullup_en(pgr_pullup_en));
    ////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        if (num_errors == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Early write refused, then delay starts at interval end
    task automatic t_start;
        host.acc(1'b1, 8'h60, 16'h0008, a, q);
        chk(a, 1'b0);
        for (int i = 0; i < 40 && por_busy; i++) @(negedge clk);
        repeat (3) @(negedge clk);
        chk(hs_drv_en, 1'b1);
        for (int i = 0; i < 400 && !power_good_output; i++) @(negedge clk);
        chk(pgr_in, 1'b1);
        for (int i = 0; i < 800 && !ls_full; i++) @(negedge clk);
        chk(ls_full, 1'b1);
        host.acc(1'b0, 8'h02, 16'h0000, a, q);
        chk(q, 16'h0017);
        host.acc(1'b0, 8'h61, 16'h0000, a, q);
        chk(q, 16'h0002);
    endtask
    // Reset role: pull-up, dropped target write, restore
    task automatic t_pin;
        host.acc(1'b1, 8'hed, 16'h0001, a, q);
        chk(pgr_pullup_en, 1'b1);
        host.acc(1'b1, 8'h21, 16'h0220, a, q);
        ext_low = 1'b1;
        host.acc(1'b1, 8'h21, 16'h0210, a, q);
        chk(a, 1'b1);
        host.acc(1'b0, 8'h21, 16'h0000, a, q);
        chk(q, st);
        ext_low = 1'b0;
        host.acc(1'b1, 8'hed, 16'h0002, a, q);
        for (int i = 0; i < 4; i++) begin
            host.acc(1'b1, 8'h29, 16'(i), a, q);
            chk(divider_ratio, 16'(i));
        end
    endtask
    // Pin turn-off cuts drivers, fault while off, gated restart
    task automatic t_off;
        en = 1'b0;
        repeat (3) @(negedge clk);
        chk(hs_drv_en | ls_drv_en, 1'b0);
        chk(power_good_output, 1'b0);
        @(posedge clk);
        #1;
        sense = 16'h0400;
        repeat (3) @(negedge clk);
        chk(ov_fault, 1'b1);
        @(posedge clk);
        #1;
        {sense, pv} = {16'h0200, 1'b0};
        @(posedge clk);
        #1;
        en = 1'b1;
        repeat (8) @(negedge clk);
        chk(hs_drv_en, 1'b0);
        @(posedge clk);
        #1;
        pv = 1'b1;
        repeat (3) @(negedge clk);
        chk(hs_drv_en, 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        t_start;
        t_pin;
        t_off;
        finish_test;
    end
    // Hang guard, well past the expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            finish_test;
        end
    end
endmodule // tb_css_sequencer
bind css_sequencer css_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .cmd_code(cmd_code),
    .cmd_wr(cmd_wr), .cmd_ack(cmd_ack), .por_busy(por_busy), .hs_drv_en(hs_drv_en),
    .ls_drv_en(ls_drv_en), .ls_limit_ff(ls_limit_ff), .ls_full(ls_full),
    .ref_level_ff(ref_level_ff), .power_good_output(power_good_output),
    .ov_fault(ov_fault), .pgr_oe_n(pgr_oe_n));
`default_nettype wire
